// ---- ibl_pkg.sv ----
// Notes on behaviour
// - top address line serves as write strobe
// - next line down serves as read strobe
// - writes are narrow positive write strobe pulses
// - eight data lines driven during writes
package ibl_pkg;

  // ***************************************
  // software register map
  // ***************************************
  localparam int unsigned REG_AW     = 8;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_RANGE  = 8'h04;
  localparam logic [7:0]  OFF_DET    = 8'h08;
  localparam logic [7:0]  OFF_STATUS = 8'h0C;
  localparam logic [7:0]  OFF_LAST   = 8'h10;
  localparam logic [7:0]  OFF_RDATA  = 8'h14;

  localparam int unsigned CTRL_RANGE_GO_BIT = 0;
  localparam int unsigned CTRL_DET_GO_BIT   = 1;
  localparam int unsigned CTRL_READ_GO_BIT  = 2;
  localparam int unsigned CTRL_RSEL_LSB     = 4;

  localparam int unsigned ST_BUSY_BIT      = 0;
  localparam int unsigned ST_LEVEL_ERR_BIT = 1;
  localparam int unsigned ST_OVERRUN_BIT   = 2;

  localparam logic [3:0] RST_LEVEL = 4'h0;
  localparam logic [7:0] RST_BYTE  = 8'h00;

  // ***************************************
  // latch select codes on address bits five..two
  // ***************************************
  localparam logic [3:0] SEL_RANGE    = 4'h6;
  localparam logic [3:0] SEL_DETECTOR = 4'h7;
  localparam logic [3:0] SEL_IDLE     = 4'h0;

  // ***************************************
  // timing
  // ***************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SETUP_NS      = 80;
  localparam int unsigned PULSE_NS      = 200;
  localparam int unsigned HOLD_NS       = 80;
  localparam int unsigned TMR_W         = 4;
  localparam logic [TMR_W-1:0] SETUP_CYC =
    TMR_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PULSE_CYC =
    TMR_W'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] HOLD_CYC =
    TMR_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ***************************************
  // full-scale level index and range byte layout
  // ***************************************
  localparam logic [3:0] LVL_0    = 4'h0;
  localparam logic [3:0] LVL_1    = 4'h1;
  localparam logic [3:0] LVL_2    = 4'h2;
  localparam logic [3:0] LVL_5    = 4'h3;
  localparam logic [3:0] LVL_10   = 4'h4;
  localparam logic [3:0] LVL_20   = 4'h5;
  localparam logic [3:0] LVL_50   = 4'h6;
  localparam logic [3:0] LVL_100  = 4'h7;
  localparam logic [3:0] LVL_200  = 4'h8;
  localparam logic [3:0] LVL_500  = 4'h9;
  localparam logic [3:0] LVL_1000 = 4'hA;

  localparam int unsigned RNG_M1_BIT   = 0;
  localparam int unsigned RNG_M2_BIT   = 1;
  localparam int unsigned RNG_M5_BIT   = 2;
  localparam int unsigned RNG_ZERO_BIT = 3;
  localparam int unsigned RNG_D100_BIT = 4;
  localparam int unsigned RNG_D10_BIT  = 5;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_HOLD  = 4'b1000
  } ibl_state_e;

  // bit order matches address lines seven down to two
  typedef struct packed {
    logic       bus_write_strobe;
    logic       bus_read_strobe;
    logic [3:0] latch_select;
  } ibl_ia_s;

endpackage

// ---- ibl_cycle_timer.sv ----
`timescale 1ns/1ps
module ibl_cycle_timer #(
  parameter int unsigned W = 4
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic              expired_o
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load_i) begin
      next_cnt = load_val_i;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign expired_o = (cnt == '0);

endmodule

// ---- ibl_range_encoder.sv ----
`timescale 1ns/1ps
module ibl_range_encoder (
  input  wire logic [3:0] level_i,
  output logic      [7:0] range_byte_o,
  output logic            valid_o
);

  always_comb begin
    range_byte_o = 8'h00;
    valid_o      = 1'b1;
    unique case (level_i)
      ibl_pkg::LVL_1, ibl_pkg::LVL_10, ibl_pkg::LVL_100: begin
        range_byte_o[ibl_pkg::RNG_M1_BIT] = 1'b1;
      end
      ibl_pkg::LVL_2, ibl_pkg::LVL_20, ibl_pkg::LVL_200: begin
        range_byte_o[ibl_pkg::RNG_M2_BIT] = 1'b1;
      end
      ibl_pkg::LVL_5, ibl_pkg::LVL_50, ibl_pkg::LVL_500, ibl_pkg::LVL_1000: begin
        range_byte_o[ibl_pkg::RNG_M5_BIT] = 1'b1;
      end
      ibl_pkg::LVL_0: begin
        range_byte_o[ibl_pkg::RNG_ZERO_BIT] = 1'b1;
      end
      default: begin
        valid_o = 1'b0;
      end
    endcase
    // decade thermometer
    if (valid_o && level_i >= ibl_pkg::LVL_10) begin
      range_byte_o[ibl_pkg::RNG_D10_BIT] = 1'b1;
    end
    if (valid_o && level_i >= ibl_pkg::LVL_100) begin
      range_byte_o[ibl_pkg::RNG_D100_BIT] = 1'b1;
    end
  end

endmodule

// ---- ibl_bus_master.sv ----
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module ibl_bus_master (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,
  output ibl_pkg::ibl_ia_s          instrument_address_lines_o,
  output logic      [7:0]           instrument_data_lines_o,
  output logic                      instrument_data_lines_oe_o,
  input  wire logic [7:0]           instrument_data_lines_i
);

  // ***************************************
  // declarations
  // ***************************************
  logic [3:0]          range_level;
  logic [7:0]          det_data;
  logic [7:0]          last_range;
  logic [7:0]          read_data;
  logic                level_err;
  logic                overrun;
  logic [31:0]         rdata;
  logic [3:0]          next_range_level;
  logic [7:0]          next_det_data;
  logic [7:0]          next_last_range;
  logic [7:0]          next_read_data;
  logic                next_level_err;
  logic                next_overrun;
  logic [31:0]         next_rdata;

  // ***************************************
  // sequencer state
  // ***************************************
  ibl_pkg::ibl_state_e state;
  ibl_pkg::ibl_state_e next_state;
  ibl_pkg::ibl_ia_s    ia;
  ibl_pkg::ibl_ia_s    next_ia;
  logic [7:0]          dout;
  logic [7:0]          next_dout;
  logic                doe;
  logic                next_doe;
  logic                is_read;
  logic                next_is_read;

  // ***************************************
  // helper wiring
  // ***************************************
  logic                   tmr_load;
  logic [ibl_pkg::TMR_W-1:0] tmr_val;
  logic                   tmr_expired;
  logic [7:0]             range_byte;
  logic                   range_valid;

  // ***************************************
  // command strobes
  // ***************************************
  logic                busy;
  logic                ctrl_wr;
  logic                status_wr;
  logic                go_range;
  logic                go_det;
  logic                go_read;
  logic                go_any;
  logic                start_ok;

  // ***************************************
  // helpers
  // ***************************************
  ibl_cycle_timer #(
    .W (ibl_pkg::TMR_W)
  ) u_timer (
    .sys_clk_i  (sys_clk_i),
    .rst_b_i    (rst_b_i),
    .load_i     (tmr_load),
    .load_val_i (tmr_val),
    .expired_o  (tmr_expired)
  );

  // ***************************************
  // range byte encoder
  // ***************************************
  ibl_range_encoder u_encoder (
    .level_i      (range_level),
    .range_byte_o (range_byte),
    .valid_o      (range_valid)
  );

  // ***************************************
  // command decode
  // ***************************************
  // busy covers the hold tail as well
  assign busy      = (state != ibl_pkg::ST_IDLE);
  assign ctrl_wr   = reg_wr_i && (reg_addr_i == ibl_pkg::OFF_CTRL);
  assign status_wr = reg_wr_i && (reg_addr_i == ibl_pkg::OFF_STATUS);
  assign go_range  = ctrl_wr && reg_wdata_i[ibl_pkg::CTRL_RANGE_GO_BIT];
  assign go_det    = ctrl_wr && reg_wdata_i[ibl_pkg::CTRL_DET_GO_BIT];
  assign go_read   = ctrl_wr && reg_wdata_i[ibl_pkg::CTRL_READ_GO_BIT];
  assign go_any    = go_range || go_det || go_read;
  // invalid level refuses a range write
  assign start_ok  = go_any && !busy && !(go_range && !range_valid);

  // ***************************************
  // software registers
  // ***************************************
  always_comb begin
    next_range_level = range_level;
    next_det_data    = det_data;
    next_level_err   = level_err;
    next_overrun     = overrun;
    if (reg_wr_i && reg_addr_i == ibl_pkg::OFF_RANGE) begin
      next_range_level = reg_wdata_i[3:0];
    end
    if (reg_wr_i && reg_addr_i == ibl_pkg::OFF_DET) begin
      next_det_data = reg_wdata_i[7:0];
    end
    // write one to clear, a new event wins over the clear
    if (status_wr && reg_wdata_i[ibl_pkg::ST_LEVEL_ERR_BIT]) begin
      next_level_err = 1'b0;
    end
    if (status_wr && reg_wdata_i[ibl_pkg::ST_OVERRUN_BIT]) begin
      next_overrun = 1'b0;
    end
    if (go_range && !busy && !range_valid) begin
      next_level_err = 1'b1;
    end
    // a go while busy is dropped, not queued
    if (go_any && busy) begin
      next_overrun = 1'b1;
    end
  end

  // ***************************************
  // software register storage
  // ***************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      range_level <= ibl_pkg::RST_LEVEL;
      det_data    <= ibl_pkg::RST_BYTE;
      level_err   <= 1'b0;
      overrun     <= 1'b0;
    end else begin
      range_level <= next_range_level;
      det_data    <= next_det_data;
      level_err   <= next_level_err;
      overrun     <= next_overrun;
    end
  end

  // ***************************************
  // register read port
  // ***************************************
  // read data stand for one cycle, else zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ibl_pkg::OFF_RANGE: begin
          next_rdata = {28'h000_0000, range_level};
        end
        ibl_pkg::OFF_DET: begin
          next_rdata = {24'h00_0000, det_data};
        end
        ibl_pkg::OFF_STATUS: begin
          next_rdata[ibl_pkg::ST_BUSY_BIT]      = busy;
          next_rdata[ibl_pkg::ST_LEVEL_ERR_BIT] = level_err;
          next_rdata[ibl_pkg::ST_OVERRUN_BIT]   = overrun;
        end
        ibl_pkg::OFF_LAST: begin
          next_rdata = {24'h00_0000, last_range};
        end
        ibl_pkg::OFF_RDATA: begin
          next_rdata = {24'h00_0000, read_data};
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // ***************************************
  // instrument bus sequencer
  // ***************************************
  always_comb begin
    next_state      = state;
    next_ia         = ia;
    next_dout       = dout;
    next_doe        = doe;
    next_is_read    = is_read;
    next_last_range = last_range;
    next_read_data  = read_data;
    tmr_load        = 1'b0;
    tmr_val         = '0;
    unique case (state)
      ibl_pkg::ST_IDLE: begin
        if (start_ok) begin
          next_state    = ibl_pkg::ST_SETUP;
          // timer ends at zero, so load one less
          tmr_load      = 1'b1;
          tmr_val       = ibl_pkg::SETUP_CYC - ibl_pkg::TMR_W'(1);
          next_is_read  = 1'b0;
          next_doe      = 1'b1;
          if (go_range) begin
            next_ia.latch_select = ibl_pkg::SEL_RANGE;
            next_dout            = range_byte;
          end else if (go_det) begin
            next_ia.latch_select = ibl_pkg::SEL_DETECTOR;
            next_dout            = det_data;
          end else begin
            // read select is free; unused codes see a floating bus
            next_ia.latch_select = reg_wdata_i[ibl_pkg::CTRL_RSEL_LSB +: 4];
            next_is_read         = 1'b1;
            next_doe             = 1'b0;
          end
        end
      end
      ibl_pkg::ST_SETUP: begin
        if (tmr_expired) begin
          next_state = ibl_pkg::ST_PULSE;
          tmr_load   = 1'b1;
          tmr_val    = ibl_pkg::PULSE_CYC - ibl_pkg::TMR_W'(1);
          if (is_read) begin
            next_ia.bus_read_strobe = 1'b1;
          end else begin
            next_ia.bus_write_strobe = 1'b1;
          end
        end
      end
      ibl_pkg::ST_PULSE: begin
        if (tmr_expired) begin
          // falling edge latches the data on the board
          next_state               = ibl_pkg::ST_HOLD;
          tmr_load                 = 1'b1;
          tmr_val                  = ibl_pkg::HOLD_CYC - ibl_pkg::TMR_W'(1);
          next_ia.bus_write_strobe = 1'b0;
          next_ia.bus_read_strobe  = 1'b0;
          // board data sampled while the read strobe still stands
          if (is_read) begin
            next_read_data = instrument_data_lines_i;
          end else if (ia.latch_select == ibl_pkg::SEL_RANGE) begin
            next_last_range = dout;
          end
        end
      end
      ibl_pkg::ST_HOLD: begin
        // select and data outlast the strobe fall
        if (tmr_expired) begin
          next_state           = ibl_pkg::ST_IDLE;
          next_ia.latch_select = ibl_pkg::SEL_IDLE;
          next_doe             = 1'b0;
        end
      end
      default: begin
        next_state = ibl_pkg::ST_IDLE;
        next_ia    = '0;
        next_doe   = 1'b0;
      end
    endcase
  end

  // ***************************************
  // sequencer registers
  // ***************************************
  // a reset in mid-pulse ends the strobe at once
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state      <= ibl_pkg::ST_IDLE;
      ia         <= '0;
      dout       <= ibl_pkg::RST_BYTE;
      doe        <= 1'b0;
      is_read    <= 1'b0;
      last_range <= ibl_pkg::RST_BYTE;
      read_data  <= ibl_pkg::RST_BYTE;
    end else begin
      state      <= next_state;
      ia         <= next_ia;
      dout       <= next_dout;
      doe        <= next_doe;
      is_read    <= next_is_read;
      last_range <= next_last_range;
      read_data  <= next_read_data;
    end
  end

  // ***************************************
  // instrument bus outputs
  // ***************************************
  assign instrument_address_lines_o = ia;
  assign instrument_data_lines_o    = dout;
  assign instrument_data_lines_oe_o = doe;

endmodule

// ---- ibl_bus_master_sva.sv ----
`timescale 1ns/1ps
module ibl_bus_master_sva (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [31:0]      reg_rdata_o,
  input  wire ibl_pkg::ibl_ia_s instrument_address_lines_o,
  input  wire logic [7:0]       instrument_data_lines_o,
  input  wire logic             instrument_data_lines_oe_o,
  input  wire logic [7:0]       instrument_data_lines_i
);
  wire logic       ws  = instrument_address_lines_o.bus_write_strobe;
  wire logic       rs  = instrument_address_lines_o.bus_read_strobe;
  wire logic [3:0] sel = instrument_address_lines_o.latch_select;
  wire logic [7:0] dat = instrument_data_lines_o;
  wire logic       oe  = instrument_data_lines_oe_o;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_wpulse;
    ws [*5] ##1 !ws;
  endsequence
  sequence s_rpulse;
    rs [*5] ##1 !rs;
  endsequence
  sequence s_release;
    (oe && sel != ibl_pkg::SEL_IDLE) [*2] ##1 (sel == ibl_pkg::SEL_IDLE && !oe);
  endsequence

  a_write_pulse_len: assert property ($rose(ws) |-> s_wpulse)
    else $error("write strobe pulse length wrong");
  a_read_pulse_len: assert property ($rose(rs) |-> s_rpulse)
    else $error("read strobe pulse length wrong");
  a_strobes_exclusive: assert property (!(ws && rs))
    else $error("read and write strobe together");
  a_write_select_ok: assert property (ws |-> oe &&
    (sel == ibl_pkg::SEL_RANGE || sel == ibl_pkg::SEL_DETECTOR))
    else $error("write strobe without latch select or drive");
  a_write_data_stable: assert property (ws |-> $stable(dat) && $stable(sel))
    else $error("data or select moved under write strobe");
  a_read_no_drive: assert property (rs |-> !oe)
    else $error("host drives data during read");
  a_setup_before: assert property ($rose(ws) |-> $past(oe, 2) && $past(sel, 2) == sel)
    else $error("select and data not set up before strobe");
  a_hold_after: assert property ($fell(ws) |-> s_release)
    else $error("select and data hold after strobe wrong");
  a_range_code: assert property (ws && sel == ibl_pkg::SEL_RANGE |-> dat[7:6] == 2'h0 &&
    (dat == 8'h08 || ($onehot(dat[2:0]) && !dat[3] && (!dat[4] || dat[5]))))
    else $error("range byte not a legal code");
endmodule

bind ibl_bus_master ibl_bus_master_sva ibl_bus_master_sva_i (
  .sys_clk_i                  (sys_clk_i),
  .rst_b_i                    (rst_b_i),
  .reg_addr_i                 (reg_addr_i),
  .reg_wdata_i                (reg_wdata_i),
  .reg_wr_i                   (reg_wr_i),
  .reg_rd_i                   (reg_rd_i),
  .reg_rdata_o                (reg_rdata_o),
  .instrument_address_lines_o (instrument_address_lines_o),
  .instrument_data_lines_o    (instrument_data_lines_o),
  .instrument_data_lines_oe_o (instrument_data_lines_oe_o),
  .instrument_data_lines_i    (instrument_data_lines_i)
);

// ---- ibl_board_model.sv ----
`timescale 1ns/1ps
module ibl_board_model (
  input  wire logic             sys_clk_i,
  input  wire ibl_pkg::ibl_ia_s ia_i,
  input  wire logic [7:0]       bus_i,
  output logic      [7:0]       drive_o,
  output logic                  range_stb_b_o,
  output logic                  det_stb_b_o,
  output logic      [7:0]       range_q_o,
  output logic      [7:0]       det_q_o
);
  logic [7:0] float_q = 8'h5A;

  // active-low strobes follow the write strobe
  assign range_stb_b_o = !(ia_i.bus_write_strobe && ia_i.latch_select == ibl_pkg::SEL_RANGE);
  assign det_stb_b_o = !(ia_i.bus_write_strobe && ia_i.latch_select == ibl_pkg::SEL_DETECTOR);

  // capture on trailing edge, hold otherwise
  always @(negedge ia_i.bus_write_strobe) begin
    if (ia_i.latch_select == ibl_pkg::SEL_RANGE) range_q_o <= bus_i;
    if (ia_i.latch_select == ibl_pkg::SEL_DETECTOR) det_q_o <= bus_i;
  end

  // undriven bus shows a changing pattern
  always @(posedge sys_clk_i) float_q <= ~float_q;
  assign drive_o = !ia_i.bus_read_strobe ? float_q :
                   ia_i.latch_select == ibl_pkg::SEL_RANGE ? range_q_o :
                   ia_i.latch_select == ibl_pkg::SEL_DETECTOR ? det_q_o : float_q;
endmodule

// ---- ibl_bus_master_tb_top.sv ----
`timescale 1ns/1ps
module ibl_bus_master_tb_top;
  logic             sys_clk;
  logic             rst_b;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_rdata;
  ibl_pkg::ibl_ia_s ia;
  logic [7:0]       dout;
  logic             oe;
  logic [7:0]       bus_wire;
  logic [7:0]       board_drive;
  logic [7:0]       range_q;
  logic [7:0]       det_q;
  int               n_mismatch = 0;
  int               checked = 0;
  int               n_rng = 0;
  int               n_det = 0;
  int               cyc = 0;

  assign bus_wire = oe ? dout : board_drive;

  ibl_bus_master ibl_bus_master_i (
    .sys_clk_i                  (sys_clk),
    .rst_b_i                    (rst_b),
    .reg_addr_i                 (reg_addr),
    .reg_wdata_i                (reg_wdata),
    .reg_wr_i                   (reg_wr),
    .reg_rd_i                   (reg_rd),
    .reg_rdata_o                (reg_rdata),
    .instrument_address_lines_o (ia),
    .instrument_data_lines_o    (dout),
    .instrument_data_lines_oe_o (oe),
    .instrument_data_lines_i    (bus_wire)
  );

  ibl_board_model ibl_board_model_i (
    .sys_clk_i     (sys_clk),
    .ia_i          (ia),
    .bus_i         (bus_wire),
    .drive_o       (board_drive),
    .range_stb_b_o (),
    .det_stb_b_o   (),
    .range_q_o     (range_q),
    .det_q_o       (det_q)
  );

  always @(negedge ibl_board_model_i.range_stb_b_o) n_rng++;
  always @(negedge ibl_board_model_i.det_stb_b_o) n_det++;

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] exp_byte(input int lvl);
    logic [7:0] b;
    b = 8'h00;
    if (lvl == 0) b = 8'h08;
    else if (lvl == 10) b = 8'h34;
    else begin
      b[(lvl - 1) % 3] = 1'b1;
      if (lvl >= 4) b[5] = 1'b1;
      if (lvl >= 7) b[4] = 1'b1;
    end
    return b;
  endfunction

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    for (int i = 0; i < 20; i++) begin
      rd_reg(ibl_pkg::OFF_STATUS, d);
      if (d[0] === 1'b0) break;
    end
    chk(32'(d[0]), 32'h0000_0000);
  endtask

  task automatic go(input logic [31:0] ctrl);
    wr_reg(ibl_pkg::OFF_CTRL, ctrl);
    wait_idle();
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_b     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_chk(ibl_pkg::OFF_STATUS, 32'h0000_0000);
    rd_chk(ibl_pkg::OFF_LAST, 32'h0000_0000);
    rd_chk(8'h18, 32'h0000_0000);
    $display("test reset done");
    for (int l = 0; l <= 10; l++) begin
      wr_reg(ibl_pkg::OFF_RANGE, 32'(l));
      go(32'h0000_0001);
      chk(32'(range_q), 32'(exp_byte(l)));
      rd_chk(ibl_pkg::OFF_LAST, 32'(exp_byte(l)));
    end
    chk(32'(n_rng), 32'h0000_000B);
    $display("test range levels done");
    wr_reg(ibl_pkg::OFF_DET, 32'h0000_00A5);
    go(32'h0000_0002);
    chk(32'(det_q), 32'h0000_00A5);
    chk(32'(range_q), 32'h0000_0034);
    go(32'h0000_0064);
    rd_chk(ibl_pkg::OFF_RDATA, 32'h0000_0034);
    go(32'h0000_0074);
    rd_chk(ibl_pkg::OFF_RDATA, 32'h0000_00A5);
    chk(32'(n_rng + n_det), 32'h0000_000C);
    $display("test detector and read done");
    wr_reg(ibl_pkg::OFF_RANGE, 32'h0000_000B);
    go(32'h0000_0001);
    rd_chk(ibl_pkg::OFF_STATUS, 32'h0000_0002);
    chk(32'(n_rng), 32'h0000_000B);
    wr_reg(ibl_pkg::OFF_STATUS, 32'h0000_0002);
    rd_chk(ibl_pkg::OFF_STATUS, 32'h0000_0000);
    wr_reg(ibl_pkg::OFF_DET, 32'h0000_005A);
    wr_reg(ibl_pkg::OFF_CTRL, 32'h0000_0002);
    wr_reg(ibl_pkg::OFF_CTRL, 32'h0000_0002);
    wait_idle();
    rd_chk(ibl_pkg::OFF_STATUS, 32'h0000_0004);
    chk(32'(det_q), 32'h0000_005A);
    chk(32'(n_det), 32'h0000_0002);
    wr_reg(ibl_pkg::OFF_STATUS, 32'h0000_0004);
    rd_chk(ibl_pkg::OFF_STATUS, 32'h0000_0000);
    $display("test refusals done");
    wr_reg(ibl_pkg::OFF_RANGE, 32'h0000_0005);
    go(32'h0000_0007);
    chk(32'(range_q), 32'(exp_byte(5)));
    chk(32'(n_rng), 32'h0000_000C);
    chk(32'(n_det), 32'h0000_0002);
    rd_chk(ibl_pkg::OFF_STATUS, 32'h0000_0000);
    $display("test priority done");
    wrap_up();
  end
endmodule
